// ---- pkg/jdb_regs.svh ----
// Operation
// - removal debounce 1, 5, 10, 20 ms
// - 3-pole latency 32 to 256 ms
// - 4-pole latency 64 to 512 ms
// - latency set by sense current ramp rate
// - insertion debounce 5 ms to 1 s
// - pause bit suspends periodic button checks
// - jack events still reported while paused
// - detection off means no jack events
// - code below first threshold: first key
// - else below second threshold: second key
// - 4-pole: periodic measurement at chosen interval
`ifndef JDB_REGS_SVH
`define JDB_REGS_SVH

// ****************************************
// register offsets and reset values
// ****************************************
`define JDB_ADDR_DEBLAT 8'hC7
`define JDB_ADDR_KEY1 8'hC8
`define JDB_ADDR_KEY2 8'hC9
`define JDB_ADDR_CTRL 8'hD0
`define JDB_ADDR_STAT 8'hD1
`define JDB_ADDR_EVT 8'hD2
`define JDB_ADDR_MASK 8'hD3
`define JDB_RST_DEBLAT 8'h34
`define JDB_RST_KEY1 8'h0A
`define JDB_RST_KEY2 8'h16
`define JDB_RST_CTRL 8'h06

// ****************************************
// timing
// ****************************************
`define JDB_CLK_NS 25
`define JDB_MS_NS 1000000
`define JDB_LAT_BASE_MS 32
`define JDB_RAMP_STEPS 256
`define JDB_RAMP_TOP 8'hFF
`define JDB_REM_MS_0 10'd1
`define JDB_REM_MS_1 10'd5
`define JDB_REM_MS_2 10'd10
`define JDB_REM_MS_3 10'd20
`define JDB_INS_MS_0 10'd5
`define JDB_INS_MS_1 10'd10
`define JDB_INS_MS_2 10'd20
`define JDB_INS_MS_3 10'd50
`define JDB_INS_MS_4 10'd100
`define JDB_INS_MS_5 10'd200
`define JDB_INS_MS_6 10'd500
`define JDB_INS_MS_7 10'd1000
`define JDB_INT_MS_0 10'd0
`define JDB_INT_MS_1 10'd2
`define JDB_INT_MS_2 10'd5
`define JDB_INT_MS_3 10'd10
`define JDB_INT_MS_4 10'd50
`define JDB_INT_MS_5 10'd100
`define JDB_INT_MS_6 10'd200
`define JDB_INT_MS_7 10'd500

`endif

// ---- pkg/jdb_pkg.sv ----
`default_nettype none
package jdb_pkg;
    typedef enum logic [1:0] {ST_OFF, ST_ABSENT, ST_DETECT, ST_PRESENT}
        jdb_state_type;

    typedef struct packed {
        logic [1:0] rem_deb;
        logic [1:0] rate;
        logic [2:0] ins_deb;
        logic pause;
    } jdb_deblat_type;

    typedef struct packed {
        logic [3:0] spare;
        logic [2:0] interval;
        logic enable;
    } jdb_ctrl_type;

    typedef struct packed {
        logic [1:0] spare;
        logic key_other;
        logic key2;
        logic key1;
        logic done;
        logic removal;
        logic insertion;
    } jdb_evt_type;
endpackage : jdb_pkg
`default_nettype wire

// ---- rtl/jdb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "jdb_regs.svh"

module jdb_top #(
    parameter int MS_CYCLES = `JDB_MS_NS / `JDB_CLK_NS
)
(
    // clocking
    input wire logic clock,
    input wire logic rst_b,
    input wire logic clk_en,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // analog side
    input wire logic jack_sense,
    input wire logic mic_present,
    output logic [7:0] mic_sense_current,
    // button measurement
    input wire logic [7:0] meas_code,
    input wire logic meas_valid,
    output logic meas_req,
    // interrupt
    output logic irq
);

    // ****************************************
    // sizes
    // ****************************************
    localparam int STEP_BASE =
        MS_CYCLES * `JDB_LAT_BASE_MS / `JDB_RAMP_STEPS;
    localparam int SW = $clog2(STEP_BASE * 8 + 1);
    localparam int PW = $clog2(MS_CYCLES + 1);

    if (STEP_BASE < 1)
    begin : g_bad_ms
        $error("MS_CYCLES too small for the ramp");
    end

    // ****************************************
    // lookup functions
    // ****************************************
    function automatic logic [9:0] rem_ms(input logic [1:0] sel);
        case (sel)
            2'h0: rem_ms = `JDB_REM_MS_0;
            2'h1: rem_ms = `JDB_REM_MS_1;
            2'h2: rem_ms = `JDB_REM_MS_2;
            default: rem_ms = `JDB_REM_MS_3;
        endcase
    endfunction : rem_ms

    function automatic logic [9:0] ins_ms(input logic [2:0] sel);
        case (sel)
            3'h0: ins_ms = `JDB_INS_MS_0;
            3'h1: ins_ms = `JDB_INS_MS_1;
            3'h2: ins_ms = `JDB_INS_MS_2;
            3'h3: ins_ms = `JDB_INS_MS_3;
            3'h4: ins_ms = `JDB_INS_MS_4;
            3'h5: ins_ms = `JDB_INS_MS_5;
            3'h6: ins_ms = `JDB_INS_MS_6;
            default: ins_ms = `JDB_INS_MS_7;
        endcase
    endfunction : ins_ms

    function automatic logic [9:0] int_ms(input logic [2:0] sel);
        case (sel)
            3'h0: int_ms = `JDB_INT_MS_0;
            3'h1: int_ms = `JDB_INT_MS_1;
            3'h2: int_ms = `JDB_INT_MS_2;
            3'h3: int_ms = `JDB_INT_MS_3;
            3'h4: int_ms = `JDB_INT_MS_4;
            3'h5: int_ms = `JDB_INT_MS_5;
            3'h6: int_ms = `JDB_INT_MS_6;
            default: int_ms = `JDB_INT_MS_7;
        endcase
    endfunction : int_ms

    // ****************************************
    // registers and state
    // ****************************************
    jdb_pkg::jdb_deblat_type deblat_r;
    jdb_pkg::jdb_ctrl_type ctrl_r;
    jdb_pkg::jdb_evt_type evt_r;
    jdb_pkg::jdb_evt_type mask_r;
    jdb_pkg::jdb_evt_type evt_set;
    jdb_pkg::jdb_state_type state_r;
    jdb_pkg::jdb_state_type state_nxt;
    logic [7:0] key1_thr_r;
    logic [7:0] key2_thr_r;
    logic [1:0] last_key_r;
    logic four_pole_r;
    logic pass_r;
    logic sense_meta_r;
    logic sense_sync_r;
    logic mic_meta_r;
    logic mic_sync_r;
    logic [PW-1:0] pre_r;
    logic [9:0] deb_ms_r;
    logic [9:0] int_cnt_r;
    logic [SW-1:0] step_r;
    logic [7:0] ramp_r;

    // ****************************************
    // register decode
    // ****************************************
    wire wr_deblat = reg_wr && (reg_addr == `JDB_ADDR_DEBLAT);
    wire wr_key1 = reg_wr && (reg_addr == `JDB_ADDR_KEY1);
    wire wr_key2 = reg_wr && (reg_addr == `JDB_ADDR_KEY2);
    wire wr_ctrl = reg_wr && (reg_addr == `JDB_ADDR_CTRL);
    wire wr_evt = reg_wr && (reg_addr == `JDB_ADDR_EVT);
    wire wr_mask = reg_wr && (reg_addr == `JDB_ADDR_MASK);

    wire [7:0] stat_word = {2'h0, last_key_r, deblat_r.pause,
        state_r == jdb_pkg::ST_DETECT, four_pole_r,
        state_r == jdb_pkg::ST_PRESENT};

    wire [7:0] rd_mux =
        (reg_addr == `JDB_ADDR_DEBLAT) ? deblat_r :
        (reg_addr == `JDB_ADDR_KEY1) ? key1_thr_r :
        (reg_addr == `JDB_ADDR_KEY2) ? key2_thr_r :
        (reg_addr == `JDB_ADDR_CTRL) ? ctrl_r :
        (reg_addr == `JDB_ADDR_STAT) ? stat_word :
        (reg_addr == `JDB_ADDR_EVT) ? evt_r :
        (reg_addr == `JDB_ADDR_MASK) ? mask_r : 8'h00;

    // ****************************************
    // millisecond tick
    // ****************************************
    // one shared prescaler: debounce and interval times are
    // exact to within one millisecond tick
    wire ms_tick = (pre_r == PW'(MS_CYCLES - 1));

    // ****************************************
    // jack debounce
    // ****************************************
    wire absent = (state_r == jdb_pkg::ST_ABSENT);
    wire in_jack = (state_r == jdb_pkg::ST_DETECT) ||
        (state_r == jdb_pkg::ST_PRESENT);
    wire deb_hit = absent ? sense_sync_r : !sense_sync_r;
    wire [9:0] deb_lim = absent ? ins_ms(deblat_r.ins_deb)
        : rem_ms(deblat_r.rem_deb);
    wire deb_done = deb_hit && (deb_ms_r > deb_lim);
    // insertion and removal watched even while paused
    wire ins_ev = absent && deb_done;
    wire rem_ev = in_jack && deb_done;

    // ****************************************
    // detection ramp
    // ****************************************
    // ramp step doubles with each rate code, so a full pass is
    // 32 ms shifted by the code
    wire [SW-1:0] step_lim = SW'(STEP_BASE) << deblat_r.rate;
    wire detecting = (state_r == jdb_pkg::ST_DETECT) && !rem_ev;
    wire step_wrap = detecting && (step_r == step_lim - SW'(1));
    wire pass_end = step_wrap && (ramp_r == `JDB_RAMP_TOP);
    // 3-pole ends after one pass 4-pole after two
    wire det_done = pass_end && (pass_r || !mic_sync_r);

    // ****************************************
    // periodic button check
    // ****************************************
    wire [9:0] int_lim = int_ms(ctrl_r.interval);
    // no checks while paused; the count restarts on resume and
    // the current settings are used from then on
    wire checking = (state_r == jdb_pkg::ST_PRESENT) && four_pole_r &&
        !deblat_r.pause && (int_lim != 10'h000) && !rem_ev;
    wire req_now = checking && ms_tick &&
        (int_cnt_r == int_lim - 10'h001);
    wire take_meas = checking && meas_valid;
    wire is_key1 = meas_code < key1_thr_r;
    wire is_key2 = !is_key1 && (meas_code < key2_thr_r);

    // ****************************************
    // state and events
    // ****************************************
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            jdb_pkg::ST_OFF:
                state_nxt = jdb_pkg::ST_ABSENT;
            jdb_pkg::ST_ABSENT:
                if (ins_ev)
                    state_nxt = jdb_pkg::ST_DETECT;
            jdb_pkg::ST_DETECT:
                if (rem_ev)
                    state_nxt = jdb_pkg::ST_ABSENT;
                else if (det_done)
                    state_nxt = jdb_pkg::ST_PRESENT;
            jdb_pkg::ST_PRESENT:
                if (rem_ev)
                    state_nxt = jdb_pkg::ST_ABSENT;
            default:
                state_nxt = jdb_pkg::ST_OFF;
        endcase
        // disabled detection sees no jack events at all
        if (!ctrl_r.enable)
            state_nxt = jdb_pkg::ST_OFF;
    end

    always_comb
    begin
        evt_set = '0;
        evt_set.insertion = ins_ev && ctrl_r.enable;
        evt_set.removal = rem_ev && ctrl_r.enable;
        evt_set.done = det_done && ctrl_r.enable;
        evt_set.key1 = take_meas && is_key1;
        evt_set.key2 = take_meas && is_key2;
        evt_set.key_other = take_meas && !is_key1 && !is_key2;
    end

    // ****************************************
    // flip-flops
    // ****************************************
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sense_meta_r <= 1'b0;
            sense_sync_r <= 1'b0;
            mic_meta_r <= 1'b0;
            mic_sync_r <= 1'b0;
        end
        else if (clk_en)
        begin
            sense_meta_r <= jack_sense;
            sense_sync_r <= sense_meta_r;
            mic_meta_r <= mic_present;
            mic_sync_r <= mic_meta_r;
        end
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            deblat_r <= `JDB_RST_DEBLAT;
            key1_thr_r <= `JDB_RST_KEY1;
            key2_thr_r <= `JDB_RST_KEY2;
            ctrl_r <= `JDB_RST_CTRL;
            mask_r <= '0;
            evt_r <= '0;
            reg_rdata <= 8'h00;
            irq <= 1'b0;
        end
        else if (clk_en)
        begin
            if (wr_deblat)
                deblat_r <= reg_wdata;
            // thresholds are stored as written codes
            if (wr_key1)
                key1_thr_r <= reg_wdata;
            if (wr_key2)
                key2_thr_r <= reg_wdata;
            if (wr_ctrl)
                ctrl_r <= {4'h0, reg_wdata[3:0]};
            if (wr_mask)
                mask_r <= {2'h0, reg_wdata[5:0]};
            // a new event wins over a write-one clear
            evt_r <= (evt_r & ~(wr_evt ? reg_wdata : 8'h00)) | evt_set;
            reg_rdata <= reg_rd ? rd_mux : 8'h00;
            irq <= |(evt_r & mask_r);
        end
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_r <= jdb_pkg::ST_OFF;
            pre_r <= '0;
            deb_ms_r <= 10'h000;
            int_cnt_r <= 10'h000;
            meas_req <= 1'b0;
        end
        else if (clk_en)
        begin
            state_r <= state_nxt;
            pre_r <= ms_tick ? '0 : pre_r + PW'(1);
            if (!deb_hit || deb_done || state_r == jdb_pkg::ST_OFF)
                deb_ms_r <= 10'h000;
            else if (ms_tick)
                deb_ms_r <= deb_ms_r + 10'h001;
            if (!checking || req_now)
                int_cnt_r <= 10'h000;
            else if (ms_tick)
                int_cnt_r <= int_cnt_r + 10'h001;
            meas_req <= req_now;
        end
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            step_r <= '0;
            ramp_r <= 8'h00;
            pass_r <= 1'b0;
            four_pole_r <= 1'b0;
            last_key_r <= 2'h0;
            mic_sense_current <= 8'h00;
        end
        else if (clk_en)
        begin
            if (!detecting || step_wrap)
                step_r <= '0;
            else
                step_r <= step_r + SW'(1);
            if (!detecting)
                ramp_r <= 8'h00;
            else if (step_wrap)
                ramp_r <= ramp_r + 8'h01;
            if (ins_ev)
            begin
                pass_r <= 1'b0;
                four_pole_r <= 1'b0;
            end
            else if (pass_end && !pass_r && mic_sync_r)
            begin
                pass_r <= 1'b1;
                four_pole_r <= 1'b1;
            end
            if (ins_ev)
                last_key_r <= 2'h0;
            else if (take_meas)
                last_key_r <= is_key1 ? 2'h1 : (is_key2 ? 2'h2 : 2'h3);
            mic_sense_current <= detecting ? ramp_r : 8'h00;
        end
    end

endmodule : jdb_top
`default_nettype wire

// ---- bench/jdb_props.sv ----
`timescale 1ns/100ps
`default_nettype none
// ****************
// port checker
// ****************
module jdb_props (
    // clocking
    input wire logic clock,
    input wire logic rst_b,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    // analog side
    input wire logic jack_sense,
    input wire logic [7:0] mic_sense_current,
    input wire logic meas_req
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (!rst_b);
    wire logic [7:0] msc = mic_sense_current;
    wire logic wr_ctl = reg_wr && reg_addr == 8'hD0;
    a_ramp_step: assert property (
        $changed(msc) |-> msc == $past(msc) + 8'h01 || msc == 8'h00)
        else $error("ramp skipped a step");
    a_ins_hold: assert property (
        $rose(jack_sense) |=> (msc == 8'h00) [*8])
        else $error("ramp before debounce");
    a_rem_stop: assert property (
        $fell(jack_sense) |-> ##[1:300] msc == 8'h00)
        else $error("ramp after removal");
    a_pause_noreq: assert property (
        reg_wr && reg_addr == 8'hC7 && reg_wdata[0]
        |-> ##3 !meas_req [*8])
        else $error("request while paused");
    a_off_noreq: assert property (
        wr_ctl && !reg_wdata[0] |-> ##3 !meas_req [*8])
        else $error("request while off");
    a_off_ramp: assert property (
        wr_ctl && !reg_wdata[0] |-> ##3 msc == 8'h00)
        else $error("ramp while off");
    a_req_pulse: assert property (
        meas_req |=> !meas_req)
        else $error("request too long");
    a_int_off: assert property (
        wr_ctl && reg_wdata[3:1] == 3'h0 |-> ##3 !meas_req [*8])
        else $error("request with interval off");
    c_req: cover property (meas_req);
    c_ramp: cover property ($rose(jack_sense) ##[1:1000] msc == 8'hFF);
    c_rem: cover property ($fell(jack_sense));
endmodule : jdb_props
bind jdb_top jdb_props u_props (.clock(clock), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .jack_sense(jack_sense), .mic_sense_current(mic_sense_current),
    .meas_req(meas_req));
`default_nettype wire

// ---- bench/jdb_jack_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// ****************
// headset model
// ****************
module jdb_jack_model (
    // bench control
    input wire logic clock,
    input wire logic plug,
    input wire logic four_pole,
    input wire logic [7:0] code,
    input wire logic [3:0] lag,
    // device side
    input wire logic meas_req,
    output logic jack_sense,
    output logic mic_present,
    output logic meas_valid,
    output logic [7:0] meas_code
);
    int w = -1;
    logic v = 1'b0;
    logic [7:0] c = 8'h00;
    assign jack_sense = plug;
    assign mic_present = plug & four_pole;
    assign meas_valid = v;
    // released bus shows the inverse so a stale code never passes
    assign meas_code = v ? c : ~c;
    always @(posedge clock)
    begin
        v <= (w == 0);
        if (w == 0)
            c <= code;
        if (meas_req)
            w <= int'(lag);
        else if (w >= 0)
            w <= w - 1;
    end
endmodule : jdb_jack_model
`default_nettype wire

// ---- bench/tb_jack_debounce_button_classify.sv ----
`timescale 1ns/100ps
`default_nettype none
// ****************
// bench
// ****************
module tb_jack_debounce_button_classify;
    localparam int MS = 8;
    localparam int RB = 2200;
    logic clock = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic plug = 1'b0, four = 1'b0;
    logic [3:0] lag = 4'h1;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, code = 8'h00;
    logic [7:0] reg_rdata, mic_i, meas_code, k1, k2, d;
    logic jack_sense, mic_present, meas_valid, meas_req, irq;
    logic [7:0] cs[8];
    int num_errors = 0, samples_checked = 0, seed = 85, cyc = 0, n, l;
    int q[$];
    int ins_ms[8] = '{5, 10, 20, 50, 100, 200, 500, 1000};
    int rem_ms[4] = '{1, 5, 10, 20};
    logic [7:0] ra[6] = '{8'hC7, 8'hC8, 8'hC9, 8'hD0, 8'hD3, 8'hFF};
    logic [7:0] rv[6] = '{8'h34, 8'h0A, 8'h16, 8'h06, 8'h00, 8'h00};
    always #12.5 clock = ~clock;
    jdb_top #(.MS_CYCLES(MS)) u_dut (.clock(clock), .rst_b(rst_b),
        .clk_en(1'b1), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .jack_sense(jack_sense), .mic_present(mic_present),
        .mic_sense_current(mic_i), .meas_code(meas_code),
        .meas_valid(meas_valid), .meas_req(meas_req), .irq(irq));
    jdb_jack_model u_far (.clock(clock), .plug(plug), .four_pole(four),
        .code(code), .lag(lag), .meas_req(meas_req),
        .jack_sense(jack_sense), .mic_present(mic_present),
        .meas_valid(meas_valid), .meas_code(meas_code));
    task automatic end_sim();
        $display("compares %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic ok(input bit c);
        chk({7'h00, c}, 8'h01);
    endtask : ok
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask : wr
    // sampling at the edge sees the value launched by the previous edge
    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(posedge clock);
        d = reg_rdata;
    endtask : rd
    task automatic clr(input logic [7:0] m);
        wr(8'hD2, m);
        repeat (2) @(posedge clock);
    endtask : clr
    task automatic wirq(input int lim);
        n = 0;
        while (irq !== 1'b1 && n < lim)
        begin
            @(posedge clock);
            n++;
        end
        ok(n < lim);
    endtask : wirq
    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            num_errors++;
            end_sim();
        end
    end
    initial
    begin
        repeat (8) @(posedge clock);
        rst_b <= 1'b1;
        foreach (ra[j])
        begin
            rd(ra[j]);
            chk(d, rv[j]);
        end
        $display("reset value test done");
        wr(8'hD3, 8'hFF);
        wr(8'hD0, 8'h01);
        for (int i = 0; i < 8; i++)
        begin
            wr(8'hC7, {i[1:0], i[1:0], i[2:0], 1'b0});
            four <= i[2];
            plug <= 1'b1;
            wirq(9000);
            l = ins_ms[i] * MS;
            ok(n >= l && n <= l + MS + 12);
            clr(8'h01);
            wirq(5000);
            l = (32 << i[1:0]) * MS * (i[2] ? 2 : 1);
            ok(n + 4 >= l - 2 && n + 4 <= l + 12);
            rd(8'hD1);
            chk({7'h00, d[1]}, {7'h00, i[2]});
            clr(8'hFF);
            plug <= 1'b0;
            wirq(400);
            l = rem_ms[i % 4] * MS;
            ok(n >= l && n <= l + MS + 12);
            rd(8'hD2);
            chk(d, 8'h02);
            clr(8'hFF);
        end
        $display("jack timing test done");
        wr(8'hC7, 8'h00);
        plug <= 1'b1;
        wirq(200);
        clr(8'hFF);
        chk({7'h00, mic_i != 8'h00}, 8'h01);
        plug <= 1'b0;
        wirq(100);
        rd(8'hD2);
        chk(d, 8'h02);
        clr(8'hFF);
        plug <= 1'b1;
        wirq(200);
        clr(8'hFF);
        wirq(700);
        clr(8'hFF);
        chk(mic_i, 8'h00);
        k1 = 8'((256 * 89 + (89 + RB) / 2) / (89 + RB));
        k2 = 8'((256 * 195 + (195 + RB) / 2) / (195 + RB));
        wr(8'hC8, k1);
        wr(8'hC9, k2);
        wr(8'hD0, 8'h03);
        wirq(60);
        // line up on one request, then time the gap to the next
        n = 0;
        while (meas_req !== 1'b1 && n < 99)
        begin
            @(posedge clock);
            n++;
        end
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (meas_req !== 1'b1 && n < 99);
        ok(n == 2 * MS);
        cs = '{k1 - 8'h01, k1, k2 - 8'h01, k2, 8'h00, 8'hFF,
            8'($random(seed)), 8'($random(seed))};
        foreach (cs[j])
        begin
            code <= cs[j];
            lag <= j[0] ? 4'h9 : 4'h1;
            q.push_back(cs[j] < k1 ? 8 : cs[j] < k2 ? 16 : 32);
            clr(8'hFF);
            wirq(60);
            rd(8'hD2);
            chk(d, 8'(q.pop_front()));
        end
        $display("button test done");
        wr(8'hC7, 8'h01);
        wr(8'hC8, 8'h00);
        code <= 8'h05;
        clr(8'hFF);
        repeat (40) @(posedge clock);
        rd(8'hD2);
        chk(d, 8'h00);
        wr(8'hC7, 8'h00);
        wirq(60);
        rd(8'hD2);
        chk(d, 8'h10);
        wr(8'hC7, 8'h01);
        clr(8'hFF);
        plug <= 1'b0;
        wirq(100);
        rd(8'hD2);
        chk(d, 8'h02);
        $display("pause test done");
        wr(8'hD0, 8'h00);
        wr(8'hD3, 8'h00);
        clr(8'hFF);
        plug <= 1'b1;
        repeat (100) @(posedge clock);
        rd(8'hD2);
        chk(d, 8'h00);
        wr(8'hD0, 8'h01);
        repeat (100) @(posedge clock);
        chk({7'h00, irq}, 8'h00);
        wr(8'hD3, 8'h01);
        repeat (2) @(posedge clock);
        chk({7'h00, irq}, 8'h01);
        clr(8'h01);
        chk({7'h00, irq}, 8'h00);
        $display("off and mask test done");
        end_sim();
    end
endmodule : tb_jack_debounce_button_classify
`default_nettype wire
